//--- inc/reset_boot_pkg.sv
// constants and types shared by the reset and boot pin logic
//
// Contract
// - system reset halts, pc zero, refetch zero
// - system reset returns control registers defaults
// - reset pin open-drain, device pulls low only
// - power-on reset halts, pc zero, refetch zero
// - power-on also reinitialises pll control registers
// - memory select low internal, high external
// - nmi interrupts despite global interrupt mask
// - nmi sense set by programmable polarity
// - compare outputs follow pwm and action control
// - unmasked low fault tristates six compare outputs
// - compare outputs stay tristated until software enables
// - every reset makes spi pins inputs
// - fault tristate acts without clock edge
package reset_boot_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] addr_control      = 4'h0;
  localparam logic [3:0] addr_action       = 4'h1;
  localparam logic [3:0] addr_pwm_level    = 4'h2;
  localparam logic [3:0] addr_spi_dir      = 4'h3;
  localparam logic [3:0] addr_pll_control  = 4'h4;
  localparam logic [3:0] addr_irq_status   = 4'h5;
  localparam logic [3:0] addr_irq_mask     = 4'h6;
  localparam logic [3:0] addr_pin_status   = 4'h7;
  localparam logic [3:0] addr_soft_reset   = 4'h8;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int ctl_global_interrupt_mask = 0;
  localparam int ctl_nmi_polarity          = 1;
  localparam int ctl_nmi_edge              = 2;
  localparam int ctl_fault_unmask          = 3;
  localparam int ctl_compare_enable        = 4;

  // ----------------------------------------
  // interrupt status fields
  // ----------------------------------------
  localparam int irq_nmi   = 0;
  localparam int irq_fault = 1;
  localparam int irq_reset = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] control_reset     = 16'h0001;
  localparam logic [11:0] action_reset      = 12'h000;
  localparam logic [5:0]  pwm_level_reset   = 6'h00;
  localparam logic [3:0]  spi_dir_reset     = 4'h0;
  localparam logic [15:0] pll_control_reset = 16'h0000;
  localparam logic [2:0]  irq_mask_reset    = 3'h0;
  localparam logic [31:0] program_counter_reset = 32'h0000_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int clk_period_ns       = 25;
  localparam int soft_reset_time_ns  = 200;
  localparam int soft_reset_cycles   = (soft_reset_time_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [1:0] {
    st_held    = 2'b00,
    st_fetch   = 2'b01,
    st_run     = 2'b10
  } run_state_t;

  function automatic logic [1:0] action_field(input logic [11:0] act, input int idx);
    action_field = act[idx*2 +: 2];
  endfunction

endpackage

//--- src/reset_sync.sv
// two-stage reset release synchroniser
`timescale 1ns/1ps
module reset_sync
  import reset_boot_pkg::*;
(
  input  wire logic clk,
  input  wire logic async_reset_n,
  output logic      sync_reset_n
);

  logic stage1;

  // ----------------------------------------
  // release synchronised to clk
  // ----------------------------------------
  always_ff @(posedge clk or negedge async_reset_n) begin
    if (!async_reset_n) begin
      stage1       <= 1'b0;
      sync_reset_n <= 1'b0;
    end else begin
      stage1       <= 1'b1;
      sync_reset_n <= stage1;
    end
  end

endmodule

//--- src/reset_boot_pin_control.sv
// reset, boot select, nmi and compare/spi pin control
`timescale 1ns/1ps
module reset_boot_pin_control
  import reset_boot_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        system_reset_in_n,
  output logic             system_reset_out_en,
  input  wire logic        power_on_reset_in_n,
  input  wire logic        program_memory_select,
  input  wire logic        nmi_in,
  input  wire logic        power_drive_fault_in_n,
  input  wire logic [5:0]  compare_pwm_level,
  input  wire logic        cpu_interrupt_ack,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  output logic             core_reset_n,
  output logic             pll_reset_n,
  output logic [31:0]      program_counter,
  output logic             fetch_external,
  output logic             fetch_active,
  output logic             nmi_request,
  output logic             maskable_gate,
  output logic             irq,
  output logic [5:0]       full_compare_outputs,
  output logic [5:0]       full_compare_out_en,
  output logic [3:0]       spi_pin_out_en
);

  // ----------------------------------------
  // reset combining
  // ----------------------------------------
  logic any_reset_n;
  logic por_reset_n;
  logic sys_sync_n;
  logic por_sync_n;
  logic soft_pull;

  assign any_reset_n = reset_n & system_reset_in_n & power_on_reset_in_n;
  assign por_reset_n = reset_n & power_on_reset_in_n;

  reset_sync u_sys_sync (
    .clk           (clk),
    .async_reset_n (any_reset_n),
    .sync_reset_n  (sys_sync_n)
  );

  reset_sync u_por_sync (
    .clk           (clk),
    .async_reset_n (por_reset_n),
    .sync_reset_n  (por_sync_n)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [15:0] control;
  logic [11:0] action;
  logic [5:0]  pwm_level;
  logic [3:0]  spi_dir;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [15:0] next_control;
  logic [11:0] next_action;
  logic [3:0]  next_spi_dir;
  logic [2:0]  next_irq_status;
  logic [2:0]  next_irq_mask;
  logic [15:0] next_rdata;
  logic [15:0] pll_control;
  logic [15:0] next_pll_control;
  logic [7:0]  soft_count;
  logic [7:0]  next_soft_count;
  logic        nmi_prev;
  logic        nmi_active;
  logic        nmi_event;
  logic        fault_event;
  logic        fault_prev;

  assign nmi_active  = nmi_in ^ ~control[ctl_nmi_polarity];
  assign nmi_event   = control[ctl_nmi_edge] ? (nmi_active & ~nmi_prev) : nmi_active;
  assign fault_event = ~power_drive_fault_in_n & fault_prev;

  always_comb begin
    next_control     = control;
    next_action      = action;
    next_spi_dir     = spi_dir;
    next_irq_mask    = irq_mask;
    next_pll_control = pll_control;
    next_irq_status  = irq_status;
    next_soft_count  = (soft_count != 8'h00) ? soft_count - 8'h01 : 8'h00;
    next_rdata       = 16'h0000;
    if (reg_write) begin
      case (reg_addr)
        addr_control:     next_control     = reg_wdata;
        addr_action:      next_action      = reg_wdata[11:0];
        addr_spi_dir:     next_spi_dir     = reg_wdata[3:0];
        addr_pll_control: next_pll_control = reg_wdata;
        addr_irq_status:  next_irq_status  = irq_status & ~reg_wdata[2:0];
        addr_irq_mask:    next_irq_mask    = reg_wdata[2:0];
        addr_soft_reset:  next_soft_count  = reg_wdata[0] ? 8'(soft_reset_cycles) : soft_count;
        default:          next_soft_count  = next_soft_count;
      endcase
    end
    // set wins over clear
    if (nmi_event) begin
      next_irq_status[irq_nmi] = 1'b1;
    end
    if (fault_event) begin
      next_irq_status[irq_fault] = 1'b1;
    end
    if (reg_read) begin
      case (reg_addr)
        addr_control:     next_rdata = control;
        addr_action:      next_rdata = {4'h0, action};
        addr_pwm_level:   next_rdata = {10'h000, pwm_level};
        addr_spi_dir:     next_rdata = {12'h000, spi_dir};
        addr_pll_control: next_rdata = pll_control;
        addr_irq_status:  next_rdata = {13'h0000, irq_status};
        addr_irq_mask:    next_rdata = {13'h0000, irq_mask};
        addr_pin_status:  next_rdata = {11'h000, program_memory_select, power_drive_fault_in_n,
                                        nmi_in, system_reset_in_n, power_on_reset_in_n};
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // registers cleared by any reset
  // ----------------------------------------
  always_ff @(posedge clk or negedge sys_sync_n) begin
    if (!sys_sync_n) begin
      control    <= control_reset;
      action     <= action_reset;
      spi_dir    <= spi_dir_reset;
      irq_mask   <= irq_mask_reset;
      irq_status <= 3'b100;
      reg_rdata  <= 16'h0000;
      nmi_prev   <= 1'b0;
      fault_prev <= 1'b0;
      pwm_level  <= pwm_level_reset;
    end else begin
      control    <= next_control;
      action     <= next_action;
      spi_dir    <= next_spi_dir;
      irq_mask   <= next_irq_mask;
      irq_status <= next_irq_status;
      reg_rdata  <= next_rdata;
      nmi_prev   <= nmi_active;
      fault_prev <= power_drive_fault_in_n;
      pwm_level  <= compare_pwm_level;
    end
  end

  // ----------------------------------------
  // pll control and soft reset count, reset by power-on reset or reset_n only
  // ----------------------------------------
  always_ff @(posedge clk or negedge por_sync_n) begin
    if (!por_sync_n) begin
      pll_control <= pll_control_reset;
      soft_count  <= 8'h00;
    end else begin
      pll_control <= next_pll_control;
      soft_count  <= next_soft_count;
    end
  end

  assign soft_pull = (soft_count != 8'h00);

  // ----------------------------------------
  // program flow and outputs
  // ----------------------------------------
  run_state_t  state;
  run_state_t  next_state;
  logic [31:0] next_pc;
  logic [5:0]  next_cmp;
  logic        pwm_allowed;

  always_comb begin
    next_state = state;
    next_pc    = program_counter;
    case (state)
      st_held: begin
        next_state = st_fetch;
        next_pc    = program_counter_reset;
      end
      st_fetch: begin
        next_state = st_run;
        next_pc    = program_counter + 32'h1;
      end
      st_run:  next_pc = program_counter + 32'h1;
      default: next_state = st_held;
    endcase
    pwm_allowed = control[ctl_compare_enable];
    for (int i = 0; i < 6; i++) begin
      case (action_field(action, i))
        2'b00:   next_cmp[i] = 1'b0;
        2'b01:   next_cmp[i] = ~pwm_level[i];
        2'b10:   next_cmp[i] = pwm_level[i];
        default: next_cmp[i] = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge sys_sync_n) begin
    if (!sys_sync_n) begin
      state                <= st_held;
      program_counter      <= program_counter_reset;
      fetch_active         <= 1'b0;
      fetch_external       <= 1'b0;
      nmi_request          <= 1'b0;
      maskable_gate        <= 1'b0;
      irq                  <= 1'b0;
      full_compare_outputs <= 6'h00;
      spi_pin_out_en       <= 4'h0;
      core_reset_n         <= 1'b0;
    end else begin
      state                <= next_state;
      program_counter      <= next_pc;
      fetch_active         <= 1'b1;
      fetch_external       <= program_memory_select;
      nmi_request          <= next_irq_status[irq_nmi] & ~cpu_interrupt_ack;
      maskable_gate        <= ~control[ctl_global_interrupt_mask];
      irq                  <= |(next_irq_status & next_irq_mask);
      full_compare_outputs <= next_cmp;
      spi_pin_out_en       <= spi_dir;
      core_reset_n         <= 1'b1;
    end
  end

  // tristate enable, cleared at once by unmasked fault
  logic fault_now_n;
  assign fault_now_n = sys_sync_n & ~(~power_drive_fault_in_n & control[ctl_fault_unmask]);

  always_ff @(posedge clk or negedge fault_now_n) begin
    if (!fault_now_n) begin
      full_compare_out_en <= 6'h00;
    end else begin
      full_compare_out_en <= {6{pwm_allowed}};
    end
  end

  // ----------------------------------------
  // open-drain reset pin and pll reset
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      system_reset_out_en <= 1'b1;
      pll_reset_n         <= 1'b0;
    end else begin
      system_reset_out_en <= soft_pull | ~por_sync_n;
      pll_reset_n         <= por_sync_n;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pc_zero_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !sys_sync_n |-> program_counter == 32'h0) else $error("pc not zero in reset");
  a_fetch_after_release: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sys_sync_n) |-> program_counter == 32'h0 ##1 program_counter == 32'h0 ##1 program_counter == 32'h1)
    else $error("bad restart");
  a_pll_por_only: assert property (@(posedge clk) disable iff (!por_sync_n)
    (por_sync_n && $stable(pll_control) && !reg_write) |=> pll_control == $past(pll_control))
    else $error("pll changed");
  a_memsel_follow: assert property (@(posedge clk) disable iff (!sys_sync_n)
    $past(sys_sync_n) |-> fetch_external == $past(program_memory_select)) else $error("memsel");
  a_nmi_ignores_mask: assert property (@(posedge clk) disable iff (!sys_sync_n)
    (nmi_event && !cpu_interrupt_ack) |=> nmi_request) else $error("nmi lost");
  a_fault_tristate: assert property (@(posedge clk) disable iff (!reset_n)
    (!power_drive_fault_in_n && control[ctl_fault_unmask]) |-> full_compare_out_en == 6'h00)
    else $error("fault not tristated");
  a_cmp_disabled: assert property (@(posedge clk) disable iff (!sys_sync_n)
    !control[ctl_compare_enable] |=> full_compare_out_en == 6'h00) else $error("cmp driven");
  a_spi_inputs: assert property (@(posedge clk) disable iff (!reset_n)
    !sys_sync_n |-> spi_pin_out_en == 4'h0) else $error("spi driven in reset");
  a_reset_pin_por: assert property (@(posedge clk) disable iff (!reset_n)
    !por_sync_n |=> system_reset_out_en) else $error("reset pin not pulled");

endmodule

//--- bench/board_model.sv
// board side of the block: reset supervisor, boot strap and fault input
`timescale 1ns/1ps
module board_model (
  input  wire logic sys_pull,
  input  wire logic por_n,
  input  wire logic sel,
  input  wire logic fault_n,
  input  wire logic system_reset_out_en,
  output wire logic system_reset_in_n,
  output wire logic power_on_reset_in_n,
  output wire logic program_memory_select,
  output wire logic power_drive_fault_in_n
);
  // pulled-up open-drain wire, board and device only pull low
  assign system_reset_in_n      = !(sys_pull || system_reset_out_en);
  assign power_on_reset_in_n    = por_n;
  assign program_memory_select  = sel;
  assign power_drive_fault_in_n = fault_n;
endmodule

//--- bench/tb_top.sv
// self-checking bench for the reset, boot and pin control block
`timescale 1ns/1ps
module tb_top
  import reset_boot_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0, sys_pull = 1'b0, por_n = 1'b0, sel = 1'b0, fault_n = 1'b1;
  logic        nmi_in = 1'b0, cpu_interrupt_ack = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, lfsr = 16'h0029, rdata, reg_rdata;
  logic [5:0]  compare_pwm_level = 6'h00, full_compare_outputs, full_compare_out_en;
  logic [11:0] act;
  logic        system_reset_in_n, system_reset_out_en, power_on_reset_in_n, program_memory_select;
  logic        power_drive_fault_in_n, core_reset_n, pll_reset_n, fetch_external, fetch_active;
  logic        nmi_request, maskable_gate, irq;
  logic [31:0] program_counter;
  logic [3:0]  spi_pin_out_en;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;

  board_model board (.sys_pull, .por_n, .sel, .fault_n, .system_reset_out_en, .system_reset_in_n,
    .power_on_reset_in_n, .program_memory_select, .power_drive_fault_in_n);
  reset_boot_pin_control uut (.clk, .reset_n, .system_reset_in_n, .system_reset_out_en,
    .power_on_reset_in_n, .program_memory_select, .nmi_in, .power_drive_fault_in_n, .compare_pwm_level,
    .cpu_interrupt_ack, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .core_reset_n,
    .pll_reset_n, .program_counter, .fetch_external, .fetch_active, .nmi_request, .maskable_gate, .irq,
    .full_compare_outputs, .full_compare_out_en, .spi_pin_out_en);

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles > 5000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  // ------
  // helpers
  // ------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [5:0] cmp_exp(input logic [11:0] a, input logic [5:0] p);
    for (int i = 0; i < 6; i++) begin
      case (a[i*2 +: 2])
        2'b00: cmp_exp[i] = 1'b0;
        2'b01: cmp_exp[i] = !p[i];
        2'b10: cmp_exp[i] = p[i];
        default: cmp_exp[i] = 1'b1;
      endcase
    end
  endfunction

  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic release_all();
    reset_n <= 1'b1;
    sys_pull <= 1'b0;
    por_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(core_reset_n, 0, "sync release");
    for (int k = 0; k < 16 && fetch_active !== 1'b1; k++) @(negedge clk);
    chk(program_counter, 0, "fetch at zero");
    @(negedge clk);
    chk(program_counter, 1, "pc advance");
    chk(full_compare_out_en, 0, "tristate");
    chk(spi_pin_out_en, 0, "spi inputs");
    chk(maskable_gate, 0, "mask set");
  endtask

  task automatic pulse_reset(input int kind);
    if (kind == 0) reset_n <= 1'b0;
    else if (kind == 1) sys_pull <= 1'b1;
    else por_n <= 1'b0;
    #2;
    chk(core_reset_n, 0, "async hold");
    chk(program_counter, 0, "pc zero");
    tick(1);
    #1;
    chk(pll_reset_n, kind == 1, "pll reset");
    tick(5);
    release_all();
  endtask

  // ------
  // sequence
  // ------
  initial begin
    tick(6);
    release_all();
    rd(4'hf, rdata);
    chk(rdata, 0, "unmapped");
    rd(addr_control, rdata);
    chk(rdata, control_reset, "control reset");
    for (int kind = 0; kind < 3; kind++) begin
      lfsr = lfsr_next(lfsr);
      wr(addr_pll_control, lfsr);
      wr(addr_control, 16'h0012);
      pulse_reset(kind);
      rd(addr_control, rdata);
      chk(rdata, control_reset, "control default");
      rd(addr_pll_control, rdata);
      chk(rdata, (kind == 1) ? lfsr : pll_control_reset, "pll kept");
    end
    wr(addr_control, 16'h0019);
    for (int n = 0; n < 8; n++) begin
      lfsr = lfsr_next(lfsr);
      act = (n < 4) ? {6{n[1:0]}} : lfsr[11:0];
      compare_pwm_level <= lfsr[15:10];
      sel <= lfsr[3];
      wr(addr_action, {4'h0, act});
      tick(2);
      #1;
      chk(full_compare_outputs, cmp_exp(act, compare_pwm_level), "compare");
      chk(fetch_external, sel, "fetch source");
      chk(full_compare_out_en, 6'h3f, "enabled");
    end
    wr(addr_control, 16'h0011);
    fault_n <= 1'b0;
    tick(2);
    #1;
    chk(full_compare_out_en, 6'h3f, "masked fault");
    fault_n <= 1'b1;
    wr(addr_control, 16'h0019);
    fault_n <= 1'b0;
    #1;
    chk(full_compare_out_en, 0, "fault tristate");
    fault_n <= 1'b1;
    for (int pol = 0; pol < 2; pol++) begin
      nmi_in <= !pol[0];
      wr(addr_control, {13'h0, pol[0], pol[0], 1'b1});
      wr(addr_irq_status, 16'h0001);
      wr(addr_irq_mask, 16'h0000);
      tick(2);
      #1;
      chk(nmi_request, 0, "nmi idle");
      tick(1);
      nmi_in <= pol[0];
      tick(4);
      #1;
      chk(nmi_request, 1, "nmi active");
      chk(irq, 0, "irq masked");
      wr(addr_irq_mask, 16'h0001);
      nmi_in <= !pol[0];
      tick(2);
      #1;
      chk(irq, 1, "irq raised");
      wr(addr_irq_status, 16'h0001);
      tick(2);
      #1;
      chk(irq, 0, "irq cleared");
      chk(nmi_request, 0, "nmi cleared");
    end
    wr(addr_soft_reset, 16'h0001);
    tick(2);
    #1;
    chk(system_reset_out_en, 1, "pin pulled");
    chk(system_reset_in_n, 0, "pin low");
    chk(core_reset_n, 0, "core held");
    tick(12);
    #1;
    chk(system_reset_out_en, 0, "pin freed");
    chk(system_reset_in_n, 1, "pull-up");
    stop_test();
  end
endmodule
